/* File: src/itf_target_core.sv */
/*
 I2C target, clear-on-read event flags with masks, fault pin and attach/interrupt pin,
 strap decode and an APB register slave.
 Assumes SCL, SDA, straps and event levels are asynchronous; pins are resolved outside.
*/
// The APB interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
module itf_target_core
   import itf_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [7:0]       paddr,
   input  wire logic [31:0]      pwdata,
   output logic      [31:0]      prdata,
   output logic                  pready,
   output logic                  pslverr,
   input  wire logic             scl_in,
   input  wire logic             sda_in,
   output logic                  sda_out,
   output logic                  sda_oe_n,
   input  wire logic             enable_in,
   input  wire logic             standalone_in,
   input  wire itf_strap_t       strap_in,
   input  wire logic [EVT_W-1:0] event_in,
   output logic                  fault_out,
   output logic                  fault_oe_n,
   output logic                  int_attach_out,
   output logic                  int_attach_oe_n,
   output itf_cfg_t              cfg
);
   logic [39:0]      sync_1;
   logic [39:0]      sync_2;
   logic [1:0]       line_s;
   logic [1:0]       line_f;
   logic             scl_d;
   logic             sda_d;
   logic             enable_d;
   logic [EVT_W-1:0] ev_s;
   itf_strap_t       strap_s;
   logic             enable_s;
   logic             standalone_s;
   itf_state_t       state;
   logic [3:0]       bitcnt;
   logic [7:0]       shreg;
   logic             rw;
   logic [7:0]       ptr;
   logic             ptr_phase;
   logic             nack;
   logic             sda_low;
   logic             start_in_high;
   logic [7:0]       ctrl;
   logic [5:0]       fault_cnt;
   logic             fault_act;
   logic [7:0]       flags [3];
   logic [7:0]       masks [3];
   logic [2:0]       irq_bits;

   // Two-flop synchronisers for every pin level
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sync_1 <= SYNC_RST;
         sync_2 <= SYNC_RST;
      end else begin
         sync_1 <= {event_in, strap_in, standalone_in, enable_in, sda_in, scl_in};
         sync_2 <= sync_1;
      end
   end

   assign line_s       = sync_2[1:0];
   assign enable_s     = sync_2[2];
   assign standalone_s = sync_2[3];
   assign strap_s      = sync_2[15:4];
   assign ev_s         = sync_2[39:16];

   // Spike filter: a new level must persist before it is accepted
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_filt
         logic [1:0] cnt;
         logic       lvl;
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               cnt <= 2'h0;
               lvl <= 1'b1;
            end else if (line_s[gi] == lvl) begin
               cnt <= 2'h0;
            end else if (cnt == FILT_CNT_MAX) begin
               lvl <= line_s[gi];
               cnt <= 2'h0;
            end else begin
               cnt <= cnt + 2'h1;
            end
         end
         assign line_f[gi] = lvl;
      end
   endgenerate

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         scl_d    <= 1'b1;
         sda_d    <= 1'b1;
         enable_d <= 1'b0;
      end else begin
         scl_d    <= line_f[0];
         sda_d    <= line_f[1];
         enable_d <= enable_s;
      end
   end

   wire scl_rise    = line_f[0] & ~scl_d;
   wire scl_fall    = ~line_f[0] & scl_d;
   wire start_det   = scl_d & line_f[0] & sda_d & ~line_f[1];
   wire stop_det    = scl_d & line_f[0] & ~sda_d & line_f[1];
   wire stop_take   = stop_det & ~start_in_high & ~start_det;
   wire enable_rise = enable_s & ~enable_d;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         start_in_high <= 1'b0;
      end else if (start_det) begin
         start_in_high <= 1'b1;
      end else if (scl_fall) begin
         start_in_high <= 1'b0;
      end
   end

   // Straps are caught when the device is enabled
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cfg <= itf_cfg_t'(CFG_RST);
      end else if (enable_rise) begin
         cfg.addr_lsb  <= strap_s.a[1:0];
         cfg.gain      <= {strap_s.c[2], strap_s.b};
         cfg.ilim_high <= |strap_s.c[1:0];
      end
   end

   // APB decode
   wire [7:0] apb_idx    = {2'h0, paddr[7:2]};
   wire       apb_mapped = (paddr <= APB_LAST_ADDR) && (paddr[1:0] == 2'h0);
   wire       apb_acc    = psel & penable;
   wire       apb_wr     = apb_acc & pwrite & apb_mapped;
   wire       apb_rd     = apb_acc & ~pwrite & apb_mapped;

   function automatic logic [7:0] reg_read(input logic [7:0] idx);
      logic [7:0] v;
      v = 8'h00;
      if (idx < IDX_MASK0) begin
         v = flags[idx[1:0]];
      end else if (idx < IDX_CTRL) begin
         v = masks[2'(idx - IDX_MASK0)];
      end else if (idx == IDX_CTRL) begin
         v = ctrl;
      end else if (idx == IDX_STATUS) begin
         v = {fault_act, ~int_attach_oe_n, standalone_s, enable_s, 2'h0, cfg.addr_lsb};
      end
      return v;
   endfunction : reg_read

   logic [7:0] i2c_rd_byte;
   always_comb i2c_rd_byte = reg_read(ptr);
   wire       i2c_quiet   = ~start_det & ~stop_take & ~standalone_s;
   wire       i2c_load    = i2c_quiet & scl_fall &
                            (((state == ST_AACK) & rw) | ((state == ST_TACK) & ~nack));
   wire       byte_done   = i2c_quiet & scl_fall & (bitcnt == BITS_PER_BYTE);
   wire       i2c_wr      = byte_done & (state == ST_RX) & ~ptr_phase;
   wire       addr_match  = (shreg[7:1] == {TARGET_ADDR_BASE[6:2], cfg.addr_lsb}) &&
                            (shreg != GENERAL_CALL);
   wire       flag_auto_clear_sel = ctrl[CTRL_AUTO_CLEAR_BIT];

   // Flags and masks per register
   genvar gk;
   generate
      for (gk = 0; gk < 3; gk++) begin : g_evt
         localparam logic [7:0] FIDX = IDX_FLAG0 + 8'(gk);
         localparam logic [7:0] MIDX = IDX_MASK0 + 8'(gk);
         logic [7:0] flag_q;
         logic [7:0] mask_q;
         wire  [7:0] src = ev_s[8*gk +: 8];
         wire  [7:0] clr = ((apb_rd && apb_idx == FIDX) ? prdata[7:0] : 8'h00) |
                           ((i2c_load && ptr == FIDX) ? i2c_rd_byte : 8'h00);
         wire  [7:0] next_flag = flag_auto_clear_sel ? ((flag_q & ~clr) | src) : src;
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               flag_q <= 8'h00;
               mask_q <= MASK_RST;
            end else begin
               flag_q <= next_flag;
               if (apb_wr && apb_idx == MIDX) begin
                  mask_q <= pwdata[7:0];
               end else if (i2c_wr && ptr == MIDX) begin
                  mask_q <= shreg;
               end
            end
         end
         assign flags[gk]    = flag_q;
         assign masks[gk]    = mask_q;
         assign irq_bits[gk] = |(flag_q & mask_q);
      end
   endgenerate

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl <= CTRL_RST;
      end else if (apb_wr && apb_idx == IDX_CTRL) begin
         ctrl <= pwdata[7:0];
      end else if (i2c_wr && ptr == IDX_CTRL) begin
         ctrl <= shreg;
      end
   end

   // APB answer: data captured in setup, zero-wait access
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prdata <= 32'h00000000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= {24'h000000, apb_mapped ? reg_read(apb_idx) : 8'h00};
      end
   end
   assign pready  = 1'b1;
   assign pslverr = apb_acc & ~apb_mapped;

   // Fault pin: deglitched, mask-free
   wire fault_any = |(ev_s & FAULT_PIN_SEL);
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         fault_cnt <= 6'h00;
         fault_act <= 1'b0;
      end else if (!fault_any) begin
         fault_cnt <= 6'h00;
         fault_act <= 1'b0;
      end else if (fault_cnt == FAULT_CNT_MAX) begin
         fault_act <= 1'b1;
      end else begin
         fault_cnt <= fault_cnt + 6'h01;
      end
   end
   assign fault_out  = 1'b0;
   assign fault_oe_n = ~fault_act;

   // Shared pin: interrupt, or attach indicator on stand-alone parts
   wire irq_any = |irq_bits;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         int_attach_oe_n <= 1'b1;
      end else begin
         int_attach_oe_n <= standalone_s ? ~ev_s[ATTACH_BIT] : ~irq_any;
      end
   end
   assign int_attach_out = 1'b0;

   // Target state machine; SDA moves only on SCL falls
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state     <= ST_IDLE;
         bitcnt    <= 4'h0;
         shreg     <= 8'h00;
         rw        <= 1'b0;
         ptr       <= 8'h00;
         ptr_phase <= 1'b0;
         nack      <= 1'b0;
         sda_low   <= 1'b0;
      end else if (standalone_s) begin
         state   <= ST_IDLE;
         sda_low <= 1'b0;
      end else if (start_det) begin
         state   <= ST_ADDR;
         bitcnt  <= 4'h0;
         sda_low <= 1'b0;
      end else if (stop_take) begin
         state   <= ST_IDLE;
         sda_low <= 1'b0;
      end else begin
         unique case (state)
            ST_IDLE, ST_IGNORE: begin
               sda_low <= 1'b0;
            end
            ST_ADDR, ST_RX: begin
               if (scl_rise) begin
                  shreg  <= {shreg[6:0], line_f[1]};
                  bitcnt <= bitcnt + 4'h1;
               end else if (byte_done) begin
                  if (state == ST_RX) begin
                     sda_low   <= 1'b1;
                     state     <= ST_RACK;
                     ptr       <= ptr_phase ? shreg : ptr + 8'h01;
                     ptr_phase <= 1'b0;
                  end else if (addr_match) begin
                     sda_low   <= 1'b1;
                     state     <= ST_AACK;
                     rw        <= shreg[0];
                     ptr_phase <= ~shreg[0];
                  end else begin
                     state <= ST_IGNORE;
                  end
               end
            end
            ST_AACK, ST_RACK: begin
               if (i2c_load) begin
                  shreg   <= i2c_rd_byte;
                  sda_low <= ~i2c_rd_byte[7];
                  ptr     <= ptr + 8'h01;
                  bitcnt  <= 4'h0;
                  state   <= ST_TX;
               end else if (scl_fall) begin
                  sda_low <= 1'b0;
                  bitcnt  <= 4'h0;
                  state   <= ST_RX;
               end
            end
            ST_TX: begin
               if (scl_rise) begin
                  bitcnt <= bitcnt + 4'h1;
               end else if (byte_done) begin
                  sda_low <= 1'b0;
                  state   <= ST_TACK;
               end else if (scl_fall) begin
                  shreg   <= {shreg[6:0], 1'b0};
                  sda_low <= ~shreg[6];
               end
            end
            ST_TACK: begin
               if (scl_rise) begin
                  nack <= line_f[1];
               end else if (i2c_load) begin
                  shreg   <= i2c_rd_byte;
                  sda_low <= ~i2c_rd_byte[7];
                  ptr     <= ptr + 8'h01;
                  bitcnt  <= 4'h0;
                  state   <= ST_TX;
               end else if (scl_fall) begin
                  state <= ST_IGNORE;
               end
            end
         endcase
      end
   end

   assign sda_out  = 1'b0;
   assign sda_oe_n = ~sda_low;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_fault_on;
      fault_any && (fault_cnt == FAULT_CNT_MAX) |=> !fault_oe_n;
   endproperty
   a_fault_on: assert property (p_fault_on) else $error("fault pin not asserted");

   property p_fault_off;
      !fault_any |=> fault_oe_n;
   endproperty
   a_fault_off: assert property (p_fault_off) else $error("fault pin held");

   property p_fault_mask_indep;
      fault_act && fault_any && (masks[0] == MASK_RST) ##1 fault_any |-> !fault_oe_n;
   endproperty
   a_fault_mask_indep: assert property (p_fault_mask_indep) else $error("mask hit fault");

   property p_int_level;
      !standalone_s ##1 !standalone_s |-> (int_attach_oe_n == !$past(irq_any));
   endproperty
   a_int_level: assert property (p_int_level) else $error("int pin mismatch");

   property p_attach;
      standalone_s && ev_s[ATTACH_BIT] |=> !int_attach_oe_n;
   endproperty
   a_attach: assert property (p_attach) else $error("attach not shown");

   property p_clr_read;
      apb_rd && (apb_idx == IDX_FLAG0) && flag_auto_clear_sel && (ev_s[7:0] == 8'h00)
         |=> ((flags[0] & $past(prdata[7:0])) == 8'h00);
   endproperty
   a_clr_read: assert property (p_clr_read) else $error("flag not cleared");

   property p_reassert;
      (ev_s[7:0] != 8'h00) |=> ((flags[0] & $past(ev_s[7:0])) == $past(ev_s[7:0]));
   endproperty
   a_reassert: assert property (p_reassert) else $error("flag lost");

   property p_gc_nack;
      (state == ST_ADDR) && byte_done && (shreg == GENERAL_CALL)
         |=> (state == ST_IGNORE) && sda_oe_n;
   endproperty
   a_gc_nack: assert property (p_gc_nack) else $error("general call acked");

   property p_ack_hold;
      (state == ST_RACK) && !scl_fall && i2c_quiet |=> !sda_oe_n;
   endproperty
   a_ack_hold: assert property (p_ack_hold) else $error("ack released early");

   property p_stop;
      stop_take && !standalone_s |=> (state == ST_IDLE) ##1 sda_oe_n;
   endproperty
   a_stop: assert property (p_stop) else $error("stop not taken");

   property p_start;
      start_det && !standalone_s |=> (state == ST_ADDR) && (bitcnt == 4'h0);
   endproperty
   a_start: assert property (p_start) else $error("start not taken");

   property p_strap;
      enable_rise |=> (cfg.ilim_high == |$past(strap_s.c[1:0])) &&
                      (cfg.gain == {$past(strap_s.c[2]), $past(strap_s.b)});
   endproperty
   a_strap: assert property (p_strap) else $error("strap decode wrong");

   c_write: cover property (i2c_wr);
   c_read: cover property (i2c_load);
   c_int: cover property ($fell(int_attach_oe_n));
   c_fault: cover property ($fell(fault_oe_n));
endmodule : itf_target_core

/* File: src/itf_pkg.sv */
/*
 Constants, carrier types and state codes for the I2C target, flag and fault-pin block.
 Assumes a 10 MHz clk and a controller-driven SCL of at most 400 kHz.
*/
package itf_pkg;
   localparam int unsigned CLK_PERIOD_NS     = 100;
   localparam int unsigned SPIKE_FILTER_NS   = 200;
   localparam int unsigned SPIKE_FILTER_CYC  = SPIKE_FILTER_NS / CLK_PERIOD_NS;
   localparam int unsigned FAULT_DEGLITCH_NS = 5000;
   localparam int unsigned FAULT_DEGLITCH_CYC =
      (FAULT_DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [1:0]  FILT_CNT_MAX = 2'(SPIKE_FILTER_CYC - 1);
   localparam logic [5:0]  FAULT_CNT_MAX = 6'(FAULT_DEGLITCH_CYC - 1);

   localparam logic [6:0]  TARGET_ADDR_BASE = 7'h30;
   localparam logic [7:0]  GENERAL_CALL     = 8'h00;
   localparam logic [3:0]  BITS_PER_BYTE    = 4'h8;

   localparam logic [7:0]  IDX_FLAG0  = 8'h00;
   localparam logic [7:0]  IDX_MASK0  = 8'h03;
   localparam logic [7:0]  IDX_CTRL   = 8'h06;
   localparam logic [7:0]  IDX_STATUS = 8'h07;
   localparam logic [7:0]  APB_LAST_ADDR = 8'h1C;
   localparam int          CTRL_AUTO_CLEAR_BIT = 0;

   localparam int          EVT_W      = 24;
   localparam int          ATTACH_BIT = 16;
   localparam logic [23:0] FAULT_PIN_SEL = 24'h00FFFF;

   localparam logic [7:0]  MASK_RST = 8'h00;
   localparam logic [7:0]  CTRL_RST = 8'h01;
   localparam logic [7:0]  CFG_RST  = 8'h00;
   localparam logic [39:0] SYNC_RST = 40'h0000000003;

   typedef struct packed {
      logic [3:0] a;
      logic [3:0] b;
      logic [3:0] c;
   } itf_strap_t;

   typedef struct packed {
      logic [4:0] gain;
      logic       ilim_high;
      logic [1:0] addr_lsb;
   } itf_cfg_t;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'h0,
      ST_ADDR   = 3'h1,
      ST_AACK   = 3'h3,
      ST_RX     = 3'h2,
      ST_RACK   = 3'h6,
      ST_TX     = 3'h7,
      ST_TACK   = 3'h5,
      ST_IGNORE = 3'h4
   } itf_state_t;
endpackage : itf_pkg

/* File: verification/itf_ctl_model.sv */
/* I2C controller model: makes SCL at 400 kHz and pulls SDA low on the wired-AND line.
 Assumes the bench resolves SDA with a pull-up. */
`timescale 1ns/1ps
module itf_ctl_model #(
   parameter int QTR_NS = 625
) (
   output logic      scl,
   output logic      drive_low,
   input  wire logic sda
);
   initial begin
      scl = 1'b1;
      drive_low = 1'b0;
   end
   // Works from an idle bus or from SCL low, so it also makes a repeated START
   task automatic start();
      #QTR_NS drive_low = 1'b0;
      #QTR_NS scl = 1'b1;
      #QTR_NS drive_low = 1'b1;
      #QTR_NS scl = 1'b0;
   endtask : start
   task automatic stop();
      #QTR_NS drive_low = 1'b1;
      #QTR_NS scl = 1'b1;
      #QTR_NS drive_low = 1'b0;
      #QTR_NS;
   endtask : stop
   // SDA moves a quarter period after SCL falls and is read mid-high
   task automatic bit_io(input logic b, output logic seen);
      #QTR_NS drive_low = !b;
      #QTR_NS scl = 1'b1;
      #QTR_NS seen = sda;
      #QTR_NS scl = 1'b0;
   endtask : bit_io
   task automatic send(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(d[i], s);
      bit_io(1'b1, s);
      ack = !s;
   endtask : send
   // Answers NACK, so every read is one byte long
   task automatic recv(output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(1'b1, s);
   endtask : recv
endmodule : itf_ctl_model

/* File: verification/itf_target_core_tb.sv */
/* Testbench for itf_target_core: APB and I2C register access, straps, fault and shared pin.
 Assumes itf_ctl_model as the I2C controller and a pull-up on SDA. */
`timescale 1ns/1ps
`define CHK(nm, e, g) \
   begin \
      tests_run++; \
      if ((g) !== (e)) begin \
         mismatches++; \
         $display("mismatch %s expected %h seen %h", nm, e, g); \
      end \
   end
module itf_target_core_tb
   import itf_pkg::*;
;
   logic             clk = 1'b0, rst = 1'b1;
   logic             psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]       paddr = 8'h00, rb;
   logic [31:0]      pwdata = 32'h0, prdata, rd;
   logic             pready, pslverr, err, sda_out, sda_oe_n, scl, ctl_low, ack;
   logic             enable_in = 1'b0, standalone_in = 1'b1;
   logic             fault_out, fault_oe_n, int_attach_out, int_attach_oe_n;
   logic [2:0]       k;
   logic [EVT_W-1:0] event_in = '0;
   itf_strap_t       strap_in = '0;
   itf_cfg_t         cfg;
   wire              sda;
   int               mismatches = 0, tests_run = 0, cycles = 0;

   assign sda = (ctl_low || !sda_oe_n) ? 1'b0 : 1'b1;
   itf_target_core itf_target_core_inst (
      .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_in(scl),
      .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .enable_in(enable_in),
      .standalone_in(standalone_in), .strap_in(strap_in), .event_in(event_in),
      .fault_out(fault_out), .fault_oe_n(fault_oe_n), .int_attach_out(int_attach_out),
      .int_attach_oe_n(int_attach_oe_n), .cfg(cfg)
   );
   itf_ctl_model itf_ctl_model_inst (.scl(scl), .drive_low(ctl_low), .sda(sda));

   always #50 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         finish_test();
      end
   end

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : finish_test

   task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic i2c_wr(input logic [7:0] a, input logic [7:0] p, input logic [7:0] d);
      itf_ctl_model_inst.start();
      itf_ctl_model_inst.send(a, k[2]);
      itf_ctl_model_inst.send(p, k[1]);
      itf_ctl_model_inst.send(d, k[0]);
      itf_ctl_model_inst.stop();
   endtask : i2c_wr

   task automatic i2c_rd(input logic [7:0] p);
      itf_ctl_model_inst.start();
      itf_ctl_model_inst.send(8'h64, k[2]);
      itf_ctl_model_inst.send(p, k[1]);
      itf_ctl_model_inst.start();
      itf_ctl_model_inst.send(8'h65, k[0]);
      itf_ctl_model_inst.recv(rb);
      itf_ctl_model_inst.stop();
   endtask : i2c_rd

   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      apb(1'b0, 8'h18, 8'h00);
      `CHK("ctrl reset", 32'h00000001, rd)
      apb(1'b0, 8'h0C, 8'h00);
      `CHK("mask0 reset", 32'h00000000, rd)
      apb(1'b0, 8'h20, 8'h00);
      `CHK("unmapped read", 33'h100000000, {err, rd})
      `CHK("pin data levels", 3'h0, {sda_out, fault_out, int_attach_out})
      $display("test reset done");
      for (int i = 0; i < 16; i++) begin
         @(posedge clk);
         enable_in <= 1'b0;
         strap_in <= {i[3:0], i[3:0], i[3:0]};
         repeat (4) @(posedge clk);
         enable_in <= 1'b1;
         repeat (6) @(posedge clk);
         `CHK("cfg", {i[2], i[3:0], i[1:0] != 2'h0, i[1:0]}, cfg)
      end
      event_in[ATTACH_BIT] <= 1'b1;
      repeat (8) @(posedge clk);
      `CHK("attach on", 1'b0, int_attach_oe_n)
      event_in[ATTACH_BIT] <= 1'b0;
      repeat (8) @(posedge clk);
      `CHK("attach off", 1'b1, int_attach_oe_n)
      $display("test straps and attach done");
      standalone_in <= 1'b0;
      enable_in <= 1'b0;
      strap_in <= 12'h200;
      repeat (4) @(posedge clk);
      enable_in <= 1'b1;
      repeat (8) @(posedge clk);
      apb(1'b0, 8'h08, 8'h00);
      event_in[0] <= 1'b1;
      repeat (40) @(posedge clk);
      `CHK("fault deglitch", 1'b1, fault_oe_n)
      repeat (20) @(posedge clk);
      `CHK("fault on", 1'b0, fault_oe_n)
      `CHK("int masked", 1'b1, int_attach_oe_n)
      apb(1'b1, 8'h0C, 8'h01);
      repeat (3) @(posedge clk);
      `CHK("int on", 1'b0, int_attach_oe_n)
      `CHK("fault unmasked", 1'b0, fault_oe_n)
      apb(1'b0, 8'h00, 8'h00);
      `CHK("flag0", 32'h00000001, rd)
      repeat (3) @(posedge clk);
      `CHK("int persists", 1'b0, int_attach_oe_n)
      event_in[0] <= 1'b0;
      repeat (5) @(posedge clk);
      `CHK("fault off", 1'b1, fault_oe_n)
      `CHK("int sticky", 1'b0, int_attach_oe_n)
      apb(1'b0, 8'h00, 8'h00);
      repeat (3) @(posedge clk);
      `CHK("int cleared", 1'b1, int_attach_oe_n)
      apb(1'b0, 8'h00, 8'h00);
      `CHK("flag0 cleared", 32'h00000000, rd)
      event_in[ATTACH_BIT] <= 1'b1;
      repeat (5) @(posedge clk);
      event_in[ATTACH_BIT] <= 1'b0;
      repeat (5) @(posedge clk);
      `CHK("attach masked", 1'b1, int_attach_oe_n)
      apb(1'b1, 8'h14, 8'h01);
      repeat (3) @(posedge clk);
      `CHK("attach int", 1'b0, int_attach_oe_n)
      apb(1'b0, 8'h08, 8'h00);
      `CHK("flag2", 32'h00000001, rd)
      apb(1'b1, 8'h18, 8'h00);
      event_in[1] <= 1'b1;
      repeat (4) @(posedge clk);
      apb(1'b0, 8'h00, 8'h00);
      `CHK("flag0 live", 32'h00000002, rd)
      event_in[1] <= 1'b0;
      repeat (4) @(posedge clk);
      apb(1'b0, 8'h00, 8'h00);
      `CHK("flag0 follows", 32'h00000000, rd)
      $display("test fault and interrupt done");
      for (int i = 0; i < 4; i++) begin
         i2c_wr({5'h0C, i[1:0], 1'h0}, 8'h04, 8'h5A);
         `CHK("addr acks", (i == 2) ? 3'h7 : 3'h0, k)
      end
      apb(1'b0, 8'h10, 8'h00);
      `CHK("mask1 by i2c", 32'h0000005A, rd)
      i2c_wr(8'h00, 8'h04, 8'h00);
      `CHK("general call", 3'h0, k)
      itf_ctl_model_inst.start();
      itf_ctl_model_inst.send(8'h64, ack);
      itf_ctl_model_inst.send(8'h04, ack);
      for (int i = 0; i < 4; i++) itf_ctl_model_inst.bit_io(1'b0, ack);
      itf_ctl_model_inst.stop();
      for (int i = 0; i < 9; i++) begin
         itf_ctl_model_inst.bit_io(1'b1, ack);
         `CHK("idle after stop", 1'b1, ack)
      end
      i2c_rd(8'h04);
      `CHK("rd acks", 3'h7, k)
      `CHK("rd after abort", 8'h5A, rb)
      i2c_rd(8'h09);
      `CHK("rd unimplemented", 8'h00, rb)
      $display("test i2c done");
      finish_test();
   end
endmodule : itf_target_core_tb
